/* logic/exception_entry_unit.sv */
// Exception and interrupt entry logic with its control registers

//////////////////////////////////////////////////////////////////////////
// Operation
// RULE1 - Odd or user-upper fetch raises address error
// RULE2 - Address error loads fault address and page
// RULE3 - Address error code 0x0E0, general vector
// RULE4 - Entry sets block, privilege, bank bits
// RULE5 - Save pc, status, stack pointer on entry
// RULE6 - Trap saves next pc, imm times four
// RULE7 - Undefined or user privileged gives 0x180
// RULE8 - Slot illegal instructions give code 0x1A0
// RULE9 - Slot faults save slot pc minus two
// RULE10 - Float disabled outside slot gives 0x800
// RULE11 - Float class: top nibble F, sysreg forms
// RULE12 - Float disabled in slot gives 0x820
// RULE13 - User break code 0x1E0, pre/post pc
// RULE14 - User break vectors to debug base optionally
// RULE15 - Float operation fault saves own pc, 0x120
// RULE16 - NMI edge writes 0x1C0, vector plus 0x600
// RULE17 - NMI ignores mask; blocked case is configurable
// RULE18 - Level interrupt above mask, unblocked, 0x200-0x3C0
// RULE19 - Level acceptance leaves the mask untouched
// RULE20 - Interrupts save following instruction address
// RULE21 - Peripheral above mask taken, code from controller
// RULE22 - Earlier ranked fault always wins over later
// RULE23 - Blocked fault except break forces manual reset
// RULE24 - All saves complete before handler fetch; squash
module exception_entry_unit #(
	parameter int addr_width = 8  // AXI address bits
) (
	input  wire logic                  clock,
	input  wire logic                  rstn,
	input  wire exc_pkg::fetch_type    fetch,
	input  wire exc_pkg::decode_type   decode,
	input  wire logic [31:0]           stack_pointer_gpr,
	input  wire exc_pkg::pc_event_type fpu_fault,
	input  wire exc_pkg::pc_event_type boundary,
	input  wire exc_pkg::break_type    user_break,
	input  wire logic                  return_from_exception,
	input  wire logic                  nmi_pin,
	input  wire logic [3:0]            encoded_level_interrupt,
	input  wire exc_pkg::periph_type   periph,
	output exc_pkg::entry_type         entry,
	output logic [31:0]                status_reg,
	input  wire logic                  axi_awvalid,
	output logic                       axi_awready,
	input  wire logic [addr_width-1:0] axi_awaddr,
	input  wire logic                  axi_wvalid,
	output logic                       axi_wready,
	input  wire logic [31:0]           axi_wdata,
	input  wire logic [3:0]            axi_wstrb,
	output logic                       axi_bvalid,
	input  wire logic                  axi_bready,
	output logic [1:0]                 axi_bresp,
	input  wire logic                  axi_arvalid,
	output logic                       axi_arready,
	input  wire logic [addr_width-1:0] axi_araddr,
	output logic                       axi_rvalid,
	input  wire logic                  axi_rready,
	output logic [31:0]                axi_rdata,
	output logic [1:0]                 axi_rresp
);

	//////////////////////////////////////////////////////////////////////
	// Elaboration check: the map needs six address bits
	if (addr_width < 6 || addr_width > 32) begin : g_check
		$error("addr_width must lie between 6 and 32");
	end

	//////////////////////////////////////////////////////////////////////
	// All state of the unit
	typedef struct packed {
		logic [12:0][31:0]       regs;       // Register file
		exc_pkg::phase_type      phase;      // Entry sequencer
		exc_pkg::entry_type      entry;      // Registered entry outputs
		logic [1:0]              nmi_sync;   // Pin synchroniser
		logic                    nmi_last;   // Previous synced level
		logic                    nmi_pend;   // Edge seen, not yet taken
		logic [3:0]              irl_meta;   // Level pins, first stage
		logic [3:0]              irl_level;  // Level pins, second stage
		logic                    aw_full;    // Write address held
		logic [addr_width-1:0]   aw_addr;
		logic                    w_full;     // Write data held
		logic [31:0]             w_data;
		logic [3:0]              w_strb;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
	} state_type;

	state_type s;       // Current state
	state_type next_s;  // Next state

	//////////////////////////////////////////////////////////////////////
	// Decoded conditions
	logic        md;        // Privileged mode
	logic        block;     // Entries blocked
	logic        fd;        // Float unit disabled
	logic [3:0]  imask;     // Interrupt mask
	logic        nmi_edge;  // Rising edge of synced pin
	logic        fpu_op;    // Float class instruction
	logic        dv;        // Decode valid
	logic        fetch_err; // Instruction address error
	logic        gen_ill;   // General illegal
	logic        slot_ill;  // Slot illegal
	logic        gen_fd;    // General float disable
	logic        slot_fd;   // Slot float disable
	logic        trap_hit;  // Trap instruction
	logic        nmi_ok;    // NMI acceptable now
	logic        irl_ok;    // Level interrupt acceptable
	logic        per_ok;    // Peripheral interrupt acceptable
	logic        take;      // Some entry happens
	logic        is_int;    // It is an interrupt
	logic        set_tea;   // Load fault address registers
	logic        set_tra;   // Load trap code
	logic [31:0] code;      // Event code
	logic [31:0] save_pc;   // Value for saved_program_counter
	logic [31:0] target;    // Handler address
	logic [3:0]  widx;      // Write register index
	logic [3:0]  ridx;      // Read register index
	logic        wmapped;   // Write hits a register
	logic        rmapped;   // Read hits a register
	logic [31:0] wmerged;   // Strobe-merged write data

	//////////////////////////////////////////////////////////////////////
	// Handshake outputs straight from state
	assign axi_awready = ~s.aw_full;
	assign axi_wready  = ~s.w_full;
	assign axi_arready = ~s.rvalid;
	assign axi_bvalid  = s.bvalid;
	assign axi_bresp   = s.bresp;
	assign axi_rvalid  = s.rvalid;
	assign axi_rdata   = s.rdata;
	assign axi_rresp   = s.rresp;
	assign entry       = s.entry;
	assign status_reg  = s.regs[exc_pkg::idx_status];

	//////////////////////////////////////////////////////////////////////
	// Fault and interrupt classification
	always_comb begin
		md       = s.regs[exc_pkg::idx_status][exc_pkg::sr_privileged_pos];
		block    = s.regs[exc_pkg::idx_status][exc_pkg::sr_block_pos];
		fd       = s.regs[exc_pkg::idx_status][exc_pkg::sr_fd_pos];
		imask    = s.regs[exc_pkg::idx_status][exc_pkg::sr_mask_lsb +: 4];
		nmi_edge = s.nmi_sync[1] & ~s.nmi_last;
		dv       = decode.valid;
		// Top nibble F minus the one undefined code, plus sysreg forms
		fpu_op   = (decode.opcode[15:12] == exc_pkg::fpu_nibble &&
			decode.opcode != exc_pkg::fpu_undefined) ||
			decode.float_sysreg; // RULE11
		fetch_err = fetch.valid && (fetch.addr[0] ||
			(~md && fetch.addr[exc_pkg::user_limit_pos])); // RULE1
		gen_ill  = dv && ~decode.in_slot && (decode.undefined ||
			(~md && decode.privileged)); // RULE7
		slot_ill = dv && decode.in_slot && (decode.undefined ||
			decode.pc_modifying || decode.pc_relative ||
			(~md && decode.privileged)); // RULE8
		gen_fd   = dv && ~decode.in_slot && fd && fpu_op; // RULE10
		slot_fd  = dv && decode.in_slot && fd && fpu_op; // RULE12
		trap_hit = dv && ~decode.in_slot && decode.trap;
		// NMI skips the mask; while blocked a control bit decides
		nmi_ok   = boundary.valid && s.nmi_pend && (~block ||
			s.regs[exc_pkg::idx_ectl][exc_pkg::ectl_nmi_pos]); // RULE17
		irl_ok   = boundary.valid && ~block &&
			s.irl_level > imask; // RULE18
		per_ok   = boundary.valid && ~block && periph.valid &&
			periph.level > imask; // RULE21
	end

	//////////////////////////////////////////////////////////////////////
	// Priority chain; the first ranked source wins, except that a higher-level peripheral beats the level interrupt
	always_comb begin
		take    = 1'b1;
		is_int  = 1'b0;
		set_tea = 1'b0;
		set_tra = 1'b0;
		code    = '0;
		save_pc = '0;
		target  = s.regs[exc_pkg::idx_vbr] + exc_pkg::vec_general; // RULE4
		// Faults are ranked in a fixed order so an earlier one wins
		if (fetch_err) begin // RULE22
			code    = exc_pkg::code_addr_error; // RULE3
			save_pc = fetch.addr;
			set_tea = 1'b1;
		end else if (slot_ill) begin
			code    = exc_pkg::code_slot_illegal;
			save_pc = decode.pc - exc_pkg::inst_size; // RULE9
		end else if (gen_ill) begin
			code    = exc_pkg::code_illegal;
			save_pc = decode.pc; // RULE5
		end else if (slot_fd) begin
			code    = exc_pkg::code_slot_fpu_dis;
			save_pc = decode.pc - exc_pkg::inst_size; // RULE9
		end else if (gen_fd) begin
			code    = exc_pkg::code_fpu_disable;
			save_pc = decode.pc;
		end else if (trap_hit) begin
			code    = exc_pkg::code_trap; // RULE6
			save_pc = decode.pc + exc_pkg::inst_size;
			set_tra = 1'b1;
		end else if (fpu_fault.valid) begin
			code    = exc_pkg::code_fpu_exc; // RULE15
			save_pc = fpu_fault.pc;
		end else if (user_break.valid) begin
			code    = exc_pkg::code_user_break; // RULE13
			save_pc = user_break.post ?
				user_break.pc + exc_pkg::inst_size : user_break.pc;
			if (s.regs[exc_pkg::idx_brk][exc_pkg::brk_debug_pos]) begin
				target = s.regs[exc_pkg::idx_dbr]; // RULE14
			end
		end else if (nmi_ok) begin
			is_int  = 1'b1;
			code    = exc_pkg::code_nmi; // RULE16
			save_pc = boundary.pc; // RULE20
		end else if (irl_ok && (~per_ok ||
			s.irl_level >= periph.level)) begin
			// Level fifteen maps to 0x200, level one to 0x3C0
			is_int  = 1'b1;
			code    = exc_pkg::code_irl_base +
				{23'h0, ~s.irl_level, 5'h00}; // RULE18
			save_pc = boundary.pc;
		end else if (per_ok) begin
			is_int  = 1'b1;
			code    = {20'h0, periph.code}; // RULE21
			save_pc = boundary.pc;
		end else begin
			take = 1'b0;
		end
		if (is_int) begin
			target = s.regs[exc_pkg::idx_vbr] + exc_pkg::vec_interrupt;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Bus address decode and byte merge
	always_comb begin
		widx    = s.aw_addr[5:2];
		ridx    = axi_araddr[5:2];
		wmapped = s.aw_addr[addr_width-1:2] <
			(addr_width-2)'(exc_pkg::reg_count);
		rmapped = axi_araddr[addr_width-1:2] <
			(addr_width-2)'(exc_pkg::reg_count);
		wmerged = s.regs[widx];
		for (int b = 0; b < 4; b++) begin
			if (s.w_strb[b]) begin
				wmerged[8*b +: 8] = s.w_data[8*b +: 8];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_s = s;
		// Pins pass two flops before anything reads them
		next_s.nmi_sync  = {s.nmi_sync[0], nmi_pin};
		next_s.nmi_last  = s.nmi_sync[1];
		next_s.irl_meta  = encoded_level_interrupt;
		next_s.irl_level = s.irl_meta;
		next_s.entry.redirect     = 1'b0;
		next_s.entry.squash       = 1'b0;
		next_s.entry.manual_reset = 1'b0;
		next_s.entry.nmi_ack      = 1'b0;
		next_s.entry.periph_ack   = 1'b0;

		// Write channel: hold address and data, commit when both held
		if (s.bvalid && axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_full && s.w_full && ~s.bvalid) begin
			if (wmapped) begin
				next_s.regs[widx] = (s.regs[widx] &
					~exc_pkg::write_mask[widx]) |
					(wmerged & exc_pkg::write_mask[widx]);
				next_s.bresp = exc_pkg::resp_okay;
			end else begin
				next_s.bresp = exc_pkg::resp_slverr;
			end
			next_s.bvalid  = 1'b1;
			next_s.aw_full = 1'b0;
			next_s.w_full  = 1'b0;
		end
		if (axi_awvalid && ~s.aw_full) begin
			next_s.aw_full = 1'b1;
			next_s.aw_addr = axi_awaddr;
		end
		if (axi_wvalid && ~s.w_full) begin
			next_s.w_full = 1'b1;
			next_s.w_data = axi_wdata;
			next_s.w_strb = axi_wstrb;
		end

		// Read channel: one-cycle answer, unmapped reads zero
		if (s.rvalid && axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (axi_arvalid && ~s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = rmapped ? s.regs[ridx] : '0;
			next_s.rresp  = rmapped ? exc_pkg::resp_okay :
				exc_pkg::resp_slverr;
		end

		// Return restores status from the saved copy
		if (return_from_exception) begin
			next_s.regs[exc_pkg::idx_status] = s.regs[exc_pkg::idx_ssr];
		end

		// A new edge is kept even in the cycle the old one is taken
		next_s.nmi_pend = s.nmi_pend | nmi_edge;

		// Entry outranks a same-cycle software write
		unique case (s.phase)
			exc_pkg::run: begin
				if (take && ~is_int && block &&
					code != exc_pkg::code_user_break) begin
					// Blocked fault: manual reset, saved copies untouched
					next_s.regs[exc_pkg::idx_exception_event_reg] =
						exc_pkg::code_manual_reset; // RULE23
					next_s.regs[exc_pkg::idx_status] =
						exc_pkg::sr_reset_value;
					next_s.regs[exc_pkg::idx_vbr] = exc_pkg::vbr_reset_value;
					next_s.entry.manual_reset = 1'b1;
					next_s.entry.target = exc_pkg::reset_vector;
					next_s.entry.redirect = 1'b1;
					next_s.entry.squash = 1'b1;
					next_s.phase = exc_pkg::redirect;
				end else if (take) begin
					next_s.regs[exc_pkg::idx_spc] = save_pc; // RULE5
					next_s.regs[exc_pkg::idx_ssr] =
						s.regs[exc_pkg::idx_status];
					next_s.regs[exc_pkg::idx_sgr] = stack_pointer_gpr;
					// Old status, so a same-cycle write loses
					next_s.regs[exc_pkg::idx_status] =
						s.regs[exc_pkg::idx_status];
					next_s.regs[exc_pkg::idx_status]
						[exc_pkg::sr_privileged_pos] = 1'b1; // RULE4
					next_s.regs[exc_pkg::idx_status]
						[exc_pkg::sr_bank_pos] = 1'b1;
					next_s.regs[exc_pkg::idx_status]
						[exc_pkg::sr_block_pos] = 1'b1; // RULE19
					if (is_int) begin
						next_s.regs[exc_pkg::idx_interrupt_event_reg] = code;
					end else begin
						next_s.regs[exc_pkg::idx_exception_event_reg] = code;
					end
					if (set_tea) begin
						next_s.regs[exc_pkg::idx_tea] = fetch.addr; // RULE2
						next_s.regs[exc_pkg::idx_page_entry_high_reg] = {
							fetch.addr[31:exc_pkg::page_entry_high_reg_vpn_lsb],
							s.regs[exc_pkg::idx_page_entry_high_reg]
								[exc_pkg::page_entry_high_reg_vpn_lsb-1:0]};
					end
					if (set_tra) begin
						next_s.regs[exc_pkg::idx_tra] =
							{22'h0, decode.trap_imm, 2'b00}; // RULE6
					end
					if (is_int && code == exc_pkg::code_nmi) begin
						next_s.nmi_pend = nmi_edge;
						next_s.entry.nmi_ack = 1'b1;
					end
					next_s.entry.periph_ack = is_int && ~nmi_ok &&
						code[11:0] == periph.code && per_ok;
					next_s.entry.target = target;
					next_s.entry.redirect = 1'b1; // RULE24
					next_s.entry.squash = 1'b1;
					next_s.phase = exc_pkg::redirect;
				end
			end
			exc_pkg::redirect: begin
				// Pulse cycle; nothing new is taken while it stands
				next_s.phase = exc_pkg::run;
			end
			default: begin
				next_s.phase = exc_pkg::run;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.phase <= exc_pkg::run;
			s.regs[exc_pkg::idx_status] <= exc_pkg::sr_reset_value;
		end else begin
			s <= next_s;
		end
	end

endmodule // exception_entry_unit

/* logic/exc_pkg.sv */
// Shared constants and carrier types of the exception entry unit
package exc_pkg;

	//////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam int          reg_count   = 13;
	localparam logic [3:0]  idx_status  = 4'h0; // status_reg
	localparam logic [3:0]  idx_spc     = 4'h1; // saved_program_counter
	localparam logic [3:0]  idx_ssr     = 4'h2; // saved_status_reg
	localparam logic [3:0]  idx_sgr     = 4'h3; // saved_stack_reg
	localparam logic [3:0]  idx_vbr     = 4'h4; // vector_base_reg
	localparam logic [3:0]  idx_dbr     = 4'h5; // debug_base_reg
	localparam logic [3:0]  idx_tea     = 4'h6; // fault_address_reg
	localparam logic [3:0]  idx_page_entry_high_reg    = 4'h7; // page_entry_high_reg
	localparam logic [3:0]  idx_exception_event_reg  = 4'h8; // exception_event_reg
	localparam logic [3:0]  idx_interrupt_event_reg  = 4'h9; // interrupt_event_reg
	localparam logic [3:0]  idx_tra     = 4'ha; // trap_code_reg
	localparam logic [3:0]  idx_brk     = 4'hb; // break_control_reg
	localparam logic [3:0]  idx_ectl    = 4'hc; // entry control

	// Writable bits per register, index 0 in the low word
	localparam logic [12:0][31:0] write_mask = {
		32'h0000_0001, 32'h0000_0001, 32'h0000_03ff, {10{32'hffff_ffff}}};

	//////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int sr_privileged_pos = 30; // privilege_bit
	localparam int sr_bank_pos       = 29; // register_bank_bit
	localparam int sr_block_pos      = 28; // block_bit
	localparam int sr_fd_pos         = 15; // float_disable_bit
	localparam int sr_mask_lsb       = 4;  // four interrupt mask bits
	localparam int brk_debug_pos     = 0;  // break_debug_enable
	localparam int ectl_nmi_pos      = 0;  // take NMI while blocked
	localparam int user_limit_pos    = 31; // upper half of address space
	localparam int page_entry_high_reg_vpn_lsb      = 10; // page number field base

	//////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [31:0] sr_reset_value  = 32'h7000_00f0;
	localparam logic [31:0] vbr_reset_value = 32'h0000_0000;
	localparam logic [31:0] reset_vector    = 32'ha000_0000;

	//////////////////////////////////////////////////////////////////////
	// Event codes and vector offsets
	localparam logic [31:0] code_manual_reset = 32'h0000_0020;
	localparam logic [31:0] code_addr_error   = 32'h0000_00e0;
	localparam logic [31:0] code_fpu_exc      = 32'h0000_0120;
	localparam logic [31:0] code_trap         = 32'h0000_0160;
	localparam logic [31:0] code_illegal      = 32'h0000_0180;
	localparam logic [31:0] code_slot_illegal = 32'h0000_01a0;
	localparam logic [31:0] code_nmi          = 32'h0000_01c0;
	localparam logic [31:0] code_user_break   = 32'h0000_01e0;
	localparam logic [31:0] code_irl_base     = 32'h0000_0200;
	localparam logic [31:0] code_fpu_disable  = 32'h0000_0800;
	localparam logic [31:0] code_slot_fpu_dis = 32'h0000_0820;
	localparam logic [31:0] vec_general       = 32'h0000_0100;
	localparam logic [31:0] vec_interrupt     = 32'h0000_0600;
	localparam logic [31:0] inst_size         = 32'h0000_0002;
	localparam logic [3:0]  fpu_nibble        = 4'hf;
	localparam logic [15:0] fpu_undefined     = 16'hfffd;
	localparam logic [1:0]  resp_okay         = 2'h0;
	localparam logic [1:0]  resp_slverr       = 2'h2;

	//////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic        valid;    // Instruction fetch issued
		logic [31:0] addr;     // Fetch virtual address
	} fetch_type;

	typedef struct packed {
		logic        valid;        // Instruction decoded this cycle
		logic [31:0] pc;           // Its address
		logic [15:0] opcode;       // Raw code
		logic        in_slot;      // Sits in a delay slot
		logic        undefined;    // Undefined code
		logic        privileged;   // Privileged, global-base forms excluded
		logic        pc_modifying; // Branch, return, trap or status load
		logic        pc_relative;  // PC-relative move or move-address
		logic        trap;         // trap_instruction
		logic [7:0]  trap_imm;     // Its immediate
		logic        float_sysreg; // Load/store of float_comm/status reg
	} decode_type;

	typedef struct packed {
		logic        valid;    // Event this cycle
		logic [31:0] pc;       // Address tied to the event
	} pc_event_type;

	typedef struct packed {
		logic        valid;    // Break condition met
		logic        post;     // Post-execution break
		logic [31:0] pc;       // Breakpoint instruction address
	} break_type;

	typedef struct packed {
		logic        valid;    // Peripheral request pending
		logic [3:0]  level;    // Its priority
		logic [11:0] code;     // Source code 0x400..0x760
	} periph_type;

	typedef struct packed {
		logic        redirect;     // Fetch from target now
		logic        squash;       // Drop younger in-flight work
		logic        manual_reset; // Blocked fault forced a reset
		logic        nmi_ack;      // NMI taken
		logic        periph_ack;   // Peripheral request taken
		logic [31:0] target;       // Handler address
	} entry_type;

	typedef enum logic [1:0] {
		run      = 2'b01,
		redirect = 2'b10
	} phase_type;

endpackage

/* bench/exception_entry_monitor.sv */
// Port checks of the exception entry unit
module exception_entry_monitor (
	input wire logic                clock,
	input wire logic                rstn,
	input wire exc_pkg::fetch_type  fetch,
	input wire exc_pkg::periph_type periph,
	input wire exc_pkg::entry_type  entry,
	input wire logic [31:0]         status_reg
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	//////////////////////////////////////////////////////////////////////
	// Odd fetch while idle
	sequence s_bad_fetch;
		fetch.valid && fetch.addr[0] && !entry.redirect;
	endsequence
	property p_bad_fetch;
		s_bad_fetch |=> entry.redirect;
	endproperty
	a_bad_fetch: assert property (p_bad_fetch)
		else $error("odd fetch not taken");
	// Blocked fault ends in the reset vector
	property p_blocked;
		s_bad_fetch ##0 status_reg[28] |=> entry.manual_reset &&
			entry.target == exc_pkg::reset_vector;
	endproperty
	a_blocked: assert property (p_blocked)
		else $error("blocked fault not reset");
	property p_bits;
		entry.redirect |-> status_reg[30:28] == 3'h7;
	endproperty
	a_bits: assert property (p_bits)
		else $error("entry bits not set");
	property p_squash;
		entry.redirect |-> entry.squash;
	endproperty
	a_squash: assert property (p_squash)
		else $error("no squash");
	// Pulse never stretches
	property p_pulse;
		entry.redirect |=> !entry.redirect && !entry.squash;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("redirect too long");
	property p_mask;
		entry.redirect && !entry.manual_reset |->
			status_reg[7:4] == $past(status_reg[7:4]);
	endproperty
	a_mask: assert property (p_mask)
		else $error("mask changed");
	property p_periph;
		entry.periph_ack |-> !$past(status_reg[28]) &&
			$past(periph.level) > $past(status_reg[7:4]);
	endproperty
	a_periph: assert property (p_periph)
		else $error("peripheral taken below mask");
	property p_ack;
		entry.nmi_ack || entry.periph_ack |-> entry.redirect;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack without entry");
endmodule // exception_entry_monitor
bind exception_entry_unit exception_entry_monitor chk (.clock, .rstn,
	.fetch, .periph, .entry, .status_reg);

/* bench/irq_break_model.sv */
// Interrupt and break controller model facing the entry unit
module irq_break_model (
	input wire logic           clock,
	input wire logic           rstn,
	input wire logic           raise, // Start a peripheral request
	input wire logic [3:0]     level,
	input wire logic [11:0]    code,
	input wire logic           hit,   // Break condition met
	input wire logic           post,
	input wire logic [31:0]    pc,
	input wire logic           ack,
	output exc_pkg::periph_type periph,
	output exc_pkg::break_type  user_break
);
	// Request stands until taken; released lines show inverted junk
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			periph <= '0;
			user_break <= '0;
		end else begin
			if (raise)
				periph <= {1'b1, level, code};
			else if (ack)
				periph <= {1'b0, ~periph.level, ~periph.code};
			user_break <= hit ? {1'b1, post, pc} :
				{1'b0, ~user_break.post, ~user_break.pc};
		end
	end
endmodule // irq_break_model

/* bench/exception_entry_unit_tb_top.sv */
// Self-checking bench of the exception entry unit
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
	$display("mismatch at %0t got %h", $time, a); end end
module exception_entry_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] pc0 = 32'h0000_2000; // Event address
	int unsigned failures = 0, compares = 0, cycles = 0;
	logic clock, rstn, nmi_pin, return_from_exception, raise, hit, post;
	logic [31:0] stack_pointer_gpr, d, axi_wdata;
	logic [3:0] encoded_level_interrupt, axi_wstrb;
	logic [1:0] r;
	logic [7:0] axi_awaddr, axi_araddr;
	logic axi_awvalid, axi_wvalid, axi_bready, axi_arvalid, axi_rready;
	logic axi_awready, axi_wready, axi_bvalid, axi_arready, axi_rvalid;
	logic [1:0] axi_bresp, axi_rresp;
	logic [31:0] axi_rdata, status_reg;
	exc_pkg::fetch_type fetch;
	exc_pkg::decode_type decode;
	exc_pkg::pc_event_type fpu_fault, boundary;
	exc_pkg::periph_type periph;
	exc_pkg::break_type user_break;
	exc_pkg::entry_type entry;
	logic [31:0] ecode [14] = '{32'h0e0, 32'h0e0, 32'h160, 32'h180,
		32'h180, 32'h1a0, 32'h800, 32'h820, 32'h120, 32'h1e0, 32'h1e0,
		32'h1c0, 32'h340, 32'h400};
	logic [31:0] espc [14] = '{32'h1001, 32'h8000_0400, pc0 + 2, pc0,
		pc0, pc0 - 2, pc0, pc0 - 2, pc0, pc0, pc0 + 2, pc0, pc0, pc0};
	logic [15:0] opc [2:7] = '{16'hc325, 16'hfffd, 16'h002b, 16'hfffd,
		16'hf00c, 16'hf00c};
	logic [5:0] flg [2:7] = '{6'h01, 6'h10, 6'h08, 6'h30, 6'h00, 6'h20};
	exception_entry_unit uut (.clock, .rstn, .fetch, .decode,
		.stack_pointer_gpr, .fpu_fault, .boundary, .user_break,
		.return_from_exception, .nmi_pin, .encoded_level_interrupt,
		.periph, .entry, .status_reg, .axi_awvalid, .axi_awready,
		.axi_awaddr, .axi_wvalid, .axi_wready, .axi_wdata, .axi_wstrb,
		.axi_bvalid, .axi_bready, .axi_bresp, .axi_arvalid, .axi_arready,
		.axi_araddr, .axi_rvalid, .axi_rready, .axi_rdata, .axi_rresp);
	irq_break_model ibm (.clock, .rstn, .raise, .level(4'h3),
		.code(12'h400), .hit, .post, .pc(pc0), .ack(entry.periph_ack),
		.periph, .user_break);
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Hang guard, far above the run's length
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			tally_and_finish();
		end
	end
	//////////////////////////////////////////////////////////////////////
	// Bus tasks; bready and rready stay high
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		{axi_awaddr, axi_wdata} <= {a, v};
		{axi_awvalid, axi_wvalid} <= 2'h3;
		do begin
			@(posedge clock);
			if (axi_awready) axi_awvalid <= 1'b0;
			if (axi_wready) axi_wvalid <= 1'b0;
		end while (!axi_bvalid);
		r = axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		axi_araddr <= a;
		axi_arvalid <= 1'b1;
		do begin
			@(posedge clock);
			if (axi_arready) axi_arvalid <= 1'b0;
		end while (!axi_rvalid);
		{d, r} = {axi_rdata, axi_rresp};
	endtask
	task automatic ck(input logic [3:0] i, input logic [31:0] e);
		rd({2'h0, i, 2'h0});
		`CHK(d, e)
	endtask
	// Raise one event; interrupts then meet a boundary
	task automatic ev(input int k);
		case (k)
			0: fetch <= {1'b1, 32'h0000_1001};
			1: fetch <= {1'b1, 32'h8000_0400};
			2, 3, 4, 5, 6, 7:
				decode <= {1'b1, pc0, opc[k], flg[k], 8'h25, 1'b0};
			8: fpu_fault <= {1'b1, pc0};
			9, 10: {hit, post} <= {1'b1, k == 10};
			11: nmi_pin <= 1'b1;
			12: encoded_level_interrupt <= 4'h5;
			default: raise <= 1'b1;
		endcase
		@(posedge clock);
		{fetch, decode, fpu_fault, hit, raise} <= '0;
		repeat (4) @(posedge clock);
		if (k > 10) boundary <= {1'b1, pc0};
		@(posedge clock);
		{boundary, nmi_pin, encoded_level_interrupt} <= '0;
		repeat (2) @(posedge clock);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		{rstn, nmi_pin, return_from_exception, raise, hit, post} = '0;
		{axi_bready, axi_rready, axi_awvalid, axi_wvalid, axi_arvalid} = 5'h18;
		{axi_awaddr, axi_araddr, axi_wdata} = '0;
		{fetch, decode, fpu_fault, boundary} = '0;
		{encoded_level_interrupt, axi_wstrb} = 8'h0f;
		stack_pointer_gpr = 32'h0000_5a5a;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		ck(4'h0, exc_pkg::sr_reset_value);
		rd(8'h34);
		`CHK(r, exc_pkg::resp_slverr)
		wr(8'h34, 32'h0);
		`CHK(r, exc_pkg::resp_slverr)
		wr(8'h10, 32'h1000);
		wr(8'h14, 32'h3000);
		for (int k = 0; k < 14; k++) begin
			wr(8'h2c, {31'h0, k == 10});
			wr(8'h00, 32'h0000_8000);
			ev(k);
			ck(k < 11 ? 4'h8 : 4'h9, ecode[k]);
			ck(4'h1, espc[k]);
			ck(4'h2, 32'h0000_8000);
			ck(4'h3, stack_pointer_gpr);
			ck(4'h0, 32'h7000_8000);
			`CHK(entry.target, k == 10 ? 32'h3000 : k > 10 ? 32'h1600 :
				32'h1100)
			$display("test %0d done", k);
		end
		ck(4'h6, 32'h8000_0400);
		ck(4'h7, 32'h8000_0400);
		ck(4'ha, 32'h94);
		wr(8'h00, 32'h0000_8050);
		ev(12);
		ck(4'h0, 32'h0000_8050);
		wr(8'h00, 32'h1000_8000);
		ev(0);
		ck(4'h8, 32'h20);
		$display("test tail done");
		tally_and_finish();
	end
endmodule // exception_entry_unit_tb_top
